// >>> event_register_serial_access.sv
// event register, status, time and parameter access over avalon-mm
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module event_register_serial_access #(
  parameter int          DEPTH      = evreg_pkg::EVT_DEPTH,
  parameter int          STORE_CYC  = int'(evreg_pkg::STORE_CYCLES),
  parameter int          MS_CYC     = int'(evreg_pkg::MS_CYCLES),
  parameter int          START_CYC  = int'(evreg_pkg::STARTUP_CYCLES),
  parameter logic [31:0] TYPE_NAME  = evreg_pkg::TYPE_NAME_DEF
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // event source, same clock
  input  wire logic        evt_valid_in,
  input  wire logic [3:0]  evt_channel_in,
  input  wire logic [10:0] evt_code_in,
  input  wire logic        auto_reset_in,
  // front buttons, asynchronous pins
  input  wire logic        btn_step_in,
  input  wire logic        btn_select_in,
  // parameter outputs
  output logic [7:0]       config_set_select_out,
  output logic             program_run_select_out,
  output logic             interlock_enable_out,
  output logic [9:0]       input_active_high_out,
  output logic [9:0]       input_signal_en_out,
  output logic [9:0]       input_opcl_en_out,
  output logic             eeprom_store_busy_out,
  output logic             display_on_out,
  output logic             irq_out
);
  localparam int REC_W = evreg_pkg::REC_W;

  // bus state
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic        req;
  logic        wr_take;
  logic        rd_take;
  // event path
  logic [REC_W-1:0] fifo_rec;
  logic             fifo_empty;
  logic             fifo_drop;
  logic             pop;
  logic [31:0]      last_q, last_d;
  logic [15:0]      now_ms;
  // status and parameters
  logic [1:0]  status_q, status_d;
  logic [7:0]  cfg_set_q, cfg_set_d;
  logic        run_q, run_d;
  logic        ilock_q, ilock_d;
  logic [9:0]  in_dir_q, in_dir_d;
  logic [9:0]  in_sig_q, in_sig_d;
  logic [9:0]  in_opcl_q, in_opcl_d;
  // eeprom store and startup
  logic [31:0] store_cnt_q, store_cnt_d;
  logic        busy_q, busy_d;
  logic        store_done;
  logic [31:0] start_cnt_q, start_cnt_d;
  logic        started_q, started_d;
  logic        factory;
  logic [1:0]  btn_s1_q, btn_s2_q;
  // interrupts
  logic [evreg_pkg::IRQ_W-1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
  logic                        irq_q, irq_d;
  logic [evreg_pkg::IRQ_W-1:0] irq_set;

  event_store #(
    .DEPTH (DEPTH),
    .W     (REC_W)
  ) u_store (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .ce_in     (ce_in),
    .push_in   (evt_valid_in),
    .rec_in    ({evt_code_in, evt_channel_in, now_ms}),
    .pop_in    (pop),
    .rec_out   (fifo_rec),
    .empty_out (fifo_empty),
    .drop_out  (fifo_drop)
  );

  seconds_timer #(
    .MS_CYC (MS_CYC)
  ) u_timer (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .load_in     (wr_take && avs_address_in == evreg_pkg::OFS_TIME),
    .load_val_in (avs_writedata_in[15:0]),
    .ms_out      (now_ms)
  );

  // button pins pass two flops; only the second stage is read
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      btn_s1_q <= 2'h0;
      btn_s2_q <= 2'h0;
    end else if (ce_in) begin
      btn_s1_q <= {btn_select_in, btn_step_in};
      btn_s2_q <= btn_s1_q;
    end
  end

  // one ack cycle per request; a write or read side effect lands on the ack edge
  always_comb begin
    req     = avs_read_in || avs_write_in;
    ack_d   = ce_in ? (req && !ack_q) : ack_q;
    wr_take = ce_in && ack_q && avs_write_in;
    rd_take = ce_in && ack_q && avs_read_in;
    // pop only a record that was really handed out; an event that lands while an
    // empty read is pending must stay stored for the next read
    pop     = rd_take && avs_address_in == evreg_pkg::OFS_EVT_READ
              && rdata_q[evreg_pkg::REC_VALID];
    rdata_d = rdata_q;
    if (ce_in && req && !ack_q) begin
      unique case (avs_address_in)
        evreg_pkg::OFS_EVT_READ:
          rdata_d = fifo_empty ? 32'h00000000 : {1'b1, fifo_rec};
        evreg_pkg::OFS_EVT_REREAD: rdata_d = last_q;
        evreg_pkg::OFS_STATUS:     rdata_d = {30'h0, status_q};
        evreg_pkg::OFS_TIME:       rdata_d = {16'h0000, now_ms};
        evreg_pkg::OFS_TYPE:       rdata_d = TYPE_NAME;
        evreg_pkg::OFS_STORE:      rdata_d = {31'h0, busy_q};
        evreg_pkg::OFS_CONFIG:     rdata_d = {22'h0, ilock_q, run_q, cfg_set_q};
        evreg_pkg::OFS_INPUT_CFG:  rdata_d = {2'h0, in_opcl_q, in_sig_q, in_dir_q};
        evreg_pkg::OFS_IRQ_STATUS: rdata_d = {29'h0, irq_st_q};
        evreg_pkg::OFS_IRQ_MASK:   rdata_d = {29'h0, irq_mask_q};
        default:                   rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // last delivered record kept apart so re-read survives later pushes
  always_comb begin
    last_d = pop ? rdata_q : last_q;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_q <= 32'h00000000;
    end else begin
      last_q <= last_d;
    end
  end

  // status flags: new events win over a clear in the same cycle
  always_comb begin
    status_d = status_q;
    if (wr_take && avs_address_in == evreg_pkg::OFS_STATUS && avs_writedata_in == 32'h0) begin
      status_d = 2'h0;
    end
    if (ce_in && auto_reset_in) begin
      status_d[evreg_pkg::ST_AUTORST] = 1'b1;
    end
    if (fifo_drop) begin
      status_d[evreg_pkg::ST_OVF] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_q <= 2'h0;
    end else begin
      status_q <= status_d;
    end
  end

  // startup window: both buttons seen at its end restore factory values
  always_comb begin
    start_cnt_d = start_cnt_q;
    started_d   = started_q;
    factory     = 1'b0;
    if (ce_in && !started_q) begin
      if (start_cnt_q == 32'(START_CYC - 1)) begin
        started_d = 1'b1;
        factory   = (btn_s2_q == 2'h3);
      end else begin
        start_cnt_d = start_cnt_q + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_cnt_q <= 32'h00000000;
      started_q   <= 1'b0;
    end else begin
      start_cnt_q <= start_cnt_d;
      started_q   <= started_d;
    end
  end

  // parameters; factory restore reloads the reset values
  always_comb begin
    cfg_set_d = cfg_set_q;
    run_d     = run_q;
    ilock_d   = ilock_q;
    in_dir_d  = in_dir_q;
    in_sig_d  = in_sig_q;
    in_opcl_d = in_opcl_q;
    if (factory) begin
      cfg_set_d = evreg_pkg::RST_CONFIG_SET;
      run_d     = evreg_pkg::RST_RUN;
      ilock_d   = evreg_pkg::RST_ILOCK;
      in_dir_d  = evreg_pkg::RST_IN_DIR;
      in_sig_d  = evreg_pkg::RST_IN_SIG;
      in_opcl_d = evreg_pkg::RST_IN_OPCL;
    end else if (wr_take && avs_address_in == evreg_pkg::OFS_CONFIG) begin
      cfg_set_d = avs_writedata_in[evreg_pkg::CFG_SET_LSB +: 8];
      run_d     = avs_writedata_in[evreg_pkg::CFG_RUN];
      ilock_d   = avs_writedata_in[evreg_pkg::CFG_ILOCK];
    end else if (wr_take && avs_address_in == evreg_pkg::OFS_INPUT_CFG) begin
      in_dir_d  = avs_writedata_in[evreg_pkg::IN_DIR_LSB +: evreg_pkg::NUM_IN];
      in_sig_d  = avs_writedata_in[evreg_pkg::IN_SIG_LSB +: evreg_pkg::NUM_IN];
      in_opcl_d = avs_writedata_in[evreg_pkg::IN_OPCL_LSB +: evreg_pkg::NUM_IN];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_set_q <= evreg_pkg::RST_CONFIG_SET;
      run_q     <= evreg_pkg::RST_RUN;
      ilock_q   <= evreg_pkg::RST_ILOCK;
      in_dir_q  <= evreg_pkg::RST_IN_DIR;
      in_sig_q  <= evreg_pkg::RST_IN_SIG;
      in_opcl_q <= evreg_pkg::RST_IN_OPCL;
    end else begin
      cfg_set_q <= cfg_set_d;
      run_q     <= run_d;
      ilock_q   <= ilock_d;
      in_dir_q  <= in_dir_d;
      in_sig_q  <= in_sig_d;
      in_opcl_q <= in_opcl_d;
    end
  end

  // eeprom store timer; a request while busy is ignored, not queued
  always_comb begin
    store_cnt_d = store_cnt_q;
    busy_d      = busy_q;
    store_done  = 1'b0;
    if (ce_in && busy_q) begin
      if (store_cnt_q == 32'(STORE_CYC - 1)) begin
        busy_d      = 1'b0;
        store_done  = 1'b1;
        store_cnt_d = 32'h00000000;
      end else begin
        store_cnt_d = store_cnt_q + 32'h00000001;
      end
    end else if (factory || (wr_take && avs_address_in == evreg_pkg::OFS_STORE
                             && avs_writedata_in == 32'h1)) begin
      busy_d      = 1'b1;
      store_cnt_d = 32'h00000000;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      store_cnt_q <= 32'h00000000;
      busy_q      <= 1'b0;
    end else begin
      store_cnt_q <= store_cnt_d;
      busy_q      <= busy_d;
    end
  end

  // sticky interrupt bits, write one to clear, set beats clear
  always_comb begin
    irq_set    = {store_done, fifo_drop, ce_in && evt_valid_in && !fifo_drop};
    irq_st_d   = irq_st_q;
    irq_mask_d = irq_mask_q;
    if (wr_take && avs_address_in == evreg_pkg::OFS_IRQ_STATUS) begin
      irq_st_d = irq_st_q & ~avs_writedata_in[evreg_pkg::IRQ_W-1:0];
    end
    if (wr_take && avs_address_in == evreg_pkg::OFS_IRQ_MASK) begin
      irq_mask_d = avs_writedata_in[evreg_pkg::IRQ_W-1:0];
    end
    irq_st_d = irq_st_d | irq_set;
    irq_d    = |(irq_st_d & irq_mask_d);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_st_q   <= '0;
      irq_mask_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      irq_st_q   <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= irq_d;
    end
  end

  // all outputs straight from flops
  always_comb begin
    avs_readdata_out       = rdata_q;
    avs_waitrequest_out    = !ack_q;
    config_set_select_out  = cfg_set_q;
    program_run_select_out = run_q;
    interlock_enable_out   = ilock_q;
    input_active_high_out  = in_dir_q;
    input_signal_en_out    = in_sig_q;
    input_opcl_en_out      = in_opcl_q;
    eeprom_store_busy_out  = busy_q;
    display_on_out         = started_q;
    irq_out                = irq_q;
  end
endmodule

// >>> evreg_pkg.sv
// constants shared by the event register access block
package evreg_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_EVT_READ   = 8'h00;
  localparam logic [7:0] OFS_EVT_REREAD = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_TIME       = 8'h0C;
  localparam logic [7:0] OFS_TYPE       = 8'h10;
  localparam logic [7:0] OFS_STORE      = 8'h14;
  localparam logic [7:0] OFS_CONFIG     = 8'h18;
  localparam logic [7:0] OFS_INPUT_CFG  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h24;
  // event record layout
  localparam int TIME_W     = 16;
  localparam int CHAN_W     = 4;
  localparam int CODE_W     = 11;
  localparam int REC_W      = TIME_W + CHAN_W + CODE_W;
  localparam int REC_VALID  = 31;
  localparam int EVT_DEPTH  = 16;
  // status code bits
  localparam int ST_AUTORST = 0;
  localparam int ST_OVF     = 1;
  // config register fields
  localparam int CFG_SET_LSB = 0;
  localparam int CFG_RUN     = 8;
  localparam int CFG_ILOCK   = 9;
  localparam logic [7:0] RST_CONFIG_SET = 8'h01;
  localparam logic       RST_RUN        = 1'b1;
  localparam logic       RST_ILOCK      = 1'b1;
  // input config fields, one bit per input 4..13
  localparam int NUM_IN      = 10;
  localparam int IN_DIR_LSB  = 0;
  localparam int IN_SIG_LSB  = 10;
  localparam int IN_OPCL_LSB = 20;
  localparam logic [9:0] RST_IN_DIR  = 10'h3FF;
  localparam logic [9:0] RST_IN_SIG  = 10'h000;
  localparam logic [9:0] RST_IN_OPCL = 10'h000;
  // interrupt bits
  localparam int IRQ_EVT   = 0;
  localparam int IRQ_OVF   = 1;
  localparam int IRQ_STORE = 2;
  localparam int IRQ_W     = 3;
  // timing
  localparam longint CLK_HZ         = 25_000_000;
  localparam longint STORE_TIME_MS  = 5000;
  localparam longint STORE_CYCLES   = (STORE_TIME_MS * CLK_HZ) / 1000;
  localparam longint MS_CYCLES      = CLK_HZ / 1000;
  localparam longint STARTUP_TIME_MS = 100;
  localparam longint STARTUP_CYCLES = (STARTUP_TIME_MS * CLK_HZ) / 1000;
  localparam logic [15:0] TIME_MAX_MS = 16'hEA5F;
  // arbitrary neutral type name "MOD1"
  localparam logic [31:0] TYPE_NAME_DEF = 32'h4D4F4431;
endpackage

// >>> event_store.sv
// event record store, oldest first, drops on full
`timescale 1ns/100ps
module event_store #(
  parameter int DEPTH = 16,
  parameter int W     = 31
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  input  wire logic         push_in,
  input  wire logic [W-1:0] rec_in,
  input  wire logic         pop_in,
  output logic [W-1:0]      rec_out,
  output logic              empty_out,
  output logic              drop_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
  logic         full;
  logic         do_push;

  // pointer arithmetic with a wrap bit gives honest full and empty
  always_comb begin
    full      = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    empty_out = (wr_q == rd_q);
    do_push   = ce_in && push_in && !full;
    drop_out  = ce_in && push_in && full;
    wr_d      = do_push ? wr_q + 1'b1 : wr_q;
    rd_d      = (ce_in && pop_in && !empty_out) ? rd_q + 1'b1 : rd_q;
    rec_out   = mem_q[rd_q[AW-1:0]];
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_q[wr_q[AW-1:0]] <= rec_in;
    end
  end
endmodule

// >>> seconds_timer.sv
// millisecond counter over one minute, loadable
`timescale 1ns/100ps
module seconds_timer #(
  parameter int MS_CYC = 25000
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        load_in,
  input  wire logic [15:0] load_val_in,
  output logic [15:0]      ms_out
);
  logic [31:0] pre_q, pre_d;
  logic [15:0] ms_q, ms_d;

  // prescaler makes one tick per millisecond, wraps at 59.999 s
  always_comb begin
    pre_d = pre_q;
    ms_d  = ms_q;
    if (ce_in) begin
      if (load_in) begin
        pre_d = '0;
        ms_d  = (load_val_in > evreg_pkg::TIME_MAX_MS) ? evreg_pkg::TIME_MAX_MS
                                                       : load_val_in;
      end else if (pre_q == 32'(MS_CYC - 1)) begin
        pre_d = '0;
        ms_d  = (ms_q == evreg_pkg::TIME_MAX_MS) ? 16'h0000 : ms_q + 16'h0001;
      end else begin
        pre_d = pre_q + 32'h00000001;
      end
    end
    ms_out = ms_q;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_q <= '0;
      ms_q  <= '0;
    end else begin
      pre_q <= pre_d;
      ms_q  <= ms_d;
    end
  end
endmodule

// >>> evreg_checker_properties.sv
// bus timing, read values and store length checks for the event access block
`timescale 1ns/100ps
module evreg_checker #(
  parameter int          STORE_CYC = 20,
  parameter logic [31:0] TYPE_NAME = 32'h0
) (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        ce_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        eeprom_store_busy_out,
  input wire logic        display_on_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic        rd_done;
  logic        wr_done;
  int unsigned busy_cnt_q;
  int unsigned busy_cnt_d;
  // a transfer completes in the cycle that waitrequest is low
  assign rd_done = avs_read_in && !avs_waitrequest_out;
  assign wr_done = avs_write_in && !avs_waitrequest_out && ce_in;
  // busy length counter, cleared whenever the store is idle
  always_comb begin
    busy_cnt_d = eeprom_store_busy_out ? busy_cnt_q + 1 : 0;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  wait_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in
    |=> !avs_waitrequest_out) else $error("bus answer late");
  wait_pulse_a: assert property (!avs_waitrequest_out && ce_in |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  type_fixed_a: assert property (rd_done && avs_address_in == evreg_pkg::OFS_TYPE
    |-> avs_readdata_out == TYPE_NAME) else $error("type name wrong");
  empty_read_a: assert property (rd_done && avs_address_in == evreg_pkg::OFS_EVT_READ
    && !avs_readdata_out[evreg_pkg::REC_VALID] |-> avs_readdata_out == 32'h0)
    else $error("empty event read not zero");
  store_start_a: assert property (wr_done && avs_address_in == evreg_pkg::OFS_STORE
    && avs_writedata_in == 32'h1 && !eeprom_store_busy_out |=> eeprom_store_busy_out)
    else $error("store did not start");
  store_length_a: assert property ($fell(eeprom_store_busy_out)
    |-> busy_cnt_q >= STORE_CYC - 1 && busy_cnt_q <= STORE_CYC + 1)
    else $error("store length wrong");
  irq_masked_a: assert property (wr_done && avs_address_in == evreg_pkg::OFS_IRQ_MASK
    && avs_writedata_in == 32'h0 |-> ##2 !irq_out) else $error("masked irq still high");
  display_hold_a: assert property (display_on_out |=> display_on_out)
    else $error("display went dark");
endmodule

bind event_register_serial_access evreg_checker #(
  .STORE_CYC(STORE_CYC), .TYPE_NAME(TYPE_NAME)) i_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .eeprom_store_busy_out(eeprom_store_busy_out), .display_on_out(display_on_out),
  .irq_out(irq_out));

// >>> communicator_model.sv
// station-side communicator: issues register transfers as bus master
`timescale 1ns/100ps
module communicator_model (
  input  wire logic        clk_in,
  input  wire logic        avs_waitrequest_in,
  input  wire logic [31:0] avs_readdata_in,
  output logic [7:0]       avs_address_out,
  output logic             avs_read_out,
  output logic             avs_write_out,
  output logic [31:0]      avs_writedata_out,
  output logic             hang_out
);
  initial begin
    avs_address_out   = 8'h00;
    avs_read_out      = 1'b0;
    avs_write_out     = 1'b0;
    avs_writedata_out = 32'h0;
    hang_out          = 1'b0;
  end
  // released address and data show the inverse, so stale values never look valid
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_out   <= a;
    avs_writedata_out <= d;
    avs_read_out      <= !w;
    avs_write_out     <= w;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_in !== 1'b0 && n < 64);
    q = avs_readdata_in;
    if (n >= 64) hang_out <= 1'b1;
    avs_address_out   <= ~a;
    avs_writedata_out <= ~d;
    avs_read_out      <= 1'b0;
    avs_write_out     <= 1'b0;
  endtask
endmodule

// >>> tb_event_register_serial_access.sv
// testbench for the event register access block
`timescale 1ns/100ps
module tb_event_register_serial_access;
  localparam int DEP = 4;
  localparam int STC = 20;
  localparam int MSC = 5;
  localparam int STA = 8;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        evt_valid = 1'b0;
  logic [3:0]  evt_ch = 4'h0;
  logic [10:0] evt_code = 11'h000;
  logic        arst = 1'b0;
  logic        btn = 1'b0;
  logic        ce = 1'b1;
  wire logic [31:0] rdata, wdata;
  wire logic [7:0]  addr, cset;
  wire logic        wreq, rd, wr, hang, run, ilock, busy, disp, irq;
  wire logic [9:0]  dir, sig, opcl;
  int          failures = 0;
  int          checks_done = 0;
  int          n;
  logic [31:0] q, r, v;
  logic [15:0] exp_q[$];

  always #20 clk_in = ~clk_in;
  event_register_serial_access #(.DEPTH(DEP), .STORE_CYC(STC), .MS_CYC(MSC), .START_CYC(STA))
  i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .evt_valid_in(evt_valid), .evt_channel_in(evt_ch),
    .evt_code_in(evt_code), .auto_reset_in(arst), .btn_step_in(btn), .btn_select_in(btn),
    .config_set_select_out(cset), .program_run_select_out(run), .interlock_enable_out(ilock),
    .input_active_high_out(dir), .input_signal_en_out(sig), .input_opcl_en_out(opcl),
    .eeprom_store_busy_out(busy), .display_on_out(disp), .irq_out(irq));
  communicator_model i_comm (.clk_in(clk_in), .avs_waitrequest_in(wreq),
    .avs_readdata_in(rdata), .avs_address_out(addr), .avs_read_out(rd), .avs_write_out(wr),
    .avs_writedata_out(wdata), .hang_out(hang));

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // a hung bus transfer ends the run
  always @(posedge hang) begin
    failures++;
    end_of_test();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // range compare for values that drift with the running timers
  task automatic chk_in(input logic [31:0] got, input int lo, input int hi);
    checks_done++;
    if ($isunknown(got) || got < lo || got > hi) begin
      failures++;
      $display("[ERR] %0t got %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    i_comm.xfer(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    i_comm.xfer(a, 1'b1, d, r);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  function automatic logic [15:0] rec_hi(input logic [3:0] c, input logic [10:0] e);
    return {1'b1, e, c};
  endfunction
  // one random event; the expected store keeps only the oldest DEP records
  task automatic ev();
    r = $urandom;
    @(posedge clk_in);
    evt_valid <= 1'b1;
    evt_ch    <= r[3:0];
    evt_code  <= r[14:4];
    if (exp_q.size() < DEP) exp_q.push_back(rec_hi(r[3:0], r[14:4]));
    @(posedge clk_in);
    evt_valid <= 1'b0;
  endtask
  // pop one record, then re-read it twice
  task automatic pop_chk();
    i_comm.xfer(evreg_pkg::OFS_EVT_READ, 1'b0, 32'h0, q);
    chk({16'h0, q[31:16]}, {16'h0, exp_q.pop_front()});
    chk_in({16'h0, q[15:0]}, 0, 59999);
    r = q;
    rdc(evreg_pkg::OFS_EVT_REREAD, r);
    rdc(evreg_pkg::OFS_EVT_REREAD, r);
  endtask
  task automatic do_reset(input logic b);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    btn      <= b;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
  endtask
  // bounded wait on the store flag; n holds the cycles spent
  task automatic wait_busy(input logic lvl);
    n = 0;
    @(negedge clk_in);
    while (busy !== lvl && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 200) begin
      failures++;
      end_of_test();
    end
  endtask

  initial begin
    r = $urandom(32'h445C);
    do_reset(1'b0);
    chk({22'h0, ilock, run, cset}, 32'h301);
    chk({2'h0, opcl, sig, dir}, 32'h3FF);
    rdc(evreg_pkg::OFS_STATUS, 32'h0);
    wr_reg(evreg_pkg::OFS_TYPE, $urandom);
    rdc(evreg_pkg::OFS_TYPE, evreg_pkg::TYPE_NAME_DEF);
    rdc(evreg_pkg::OFS_EVT_READ, 32'h0);
    rdc(8'h3C, 32'h0);
    rdc(evreg_pkg::OFS_IRQ_MASK, 32'h0);
    cyc(STA);
    chk({30'h0, disp, busy}, 32'h2);
    // records come out oldest first, once each
    repeat (3) ev();
    repeat (3) pop_chk();
    rdc(evreg_pkg::OFS_EVT_READ, 32'h0);
    rdc(evreg_pkg::OFS_EVT_REREAD, r);
    // time load, then the wrap at one minute
    wr_reg(evreg_pkg::OFS_TIME, 32'h4D2);
    i_comm.xfer(evreg_pkg::OFS_TIME, 1'b0, 32'h0, q);
    chk_in(q, 1234, 1235);
    wr_reg(evreg_pkg::OFS_TIME, 32'hEA5F);
    cyc(2 * MSC);
    i_comm.xfer(evreg_pkg::OFS_TIME, 1'b0, 32'h0, q);
    chk_in(q, 0, 3);
    // clock enable low freezes the timer; twenty idle cycles would add four ms
    wr_reg(evreg_pkg::OFS_TIME, 32'h64);
    @(posedge clk_in);
    ce <= 1'b0;
    repeat (4 * MSC) @(posedge clk_in);
    ce <= 1'b1;
    i_comm.xfer(evreg_pkg::OFS_TIME, 1'b0, 32'h0, q);
    chk_in(q, 100, 101);
    // overflow with event and overflow interrupts unmasked, then clearing
    wr_reg(evreg_pkg::OFS_IRQ_MASK, 32'h3);
    wr_reg(evreg_pkg::OFS_IRQ_STATUS, 32'h7);
    repeat (DEP + 2) ev();
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    rdc(evreg_pkg::OFS_STATUS, 32'h2);
    @(posedge clk_in);
    arst <= 1'b1;
    @(posedge clk_in);
    arst <= 1'b0;
    rdc(evreg_pkg::OFS_STATUS, 32'h3);
    wr_reg(evreg_pkg::OFS_STATUS, 32'h1);
    rdc(evreg_pkg::OFS_STATUS, 32'h3);
    wr_reg(evreg_pkg::OFS_STATUS, 32'h0);
    rdc(evreg_pkg::OFS_STATUS, 32'h0);
    rdc(evreg_pkg::OFS_IRQ_STATUS, 32'h3);
    wr_reg(evreg_pkg::OFS_IRQ_STATUS, 32'h3);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    repeat (DEP) pop_chk();
    // a masked event sets status but not the line
    wr_reg(evreg_pkg::OFS_IRQ_MASK, 32'h0);
    ev();
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rdc(evreg_pkg::OFS_IRQ_STATUS, 32'h1);
    pop_chk();
    // parameter change, then store; a value other than 1 starts nothing
    wr_reg(evreg_pkg::OFS_CONFIG, 32'h102);
    cyc(0);
    chk({22'h0, ilock, run, cset}, 32'h102);
    rdc(evreg_pkg::OFS_CONFIG, 32'h102);
    // random input configuration reaches the pins and reads back
    v = {2'h0, 30'($urandom)};
    wr_reg(evreg_pkg::OFS_INPUT_CFG, v);
    cyc(0);
    chk({2'h0, opcl, sig, dir}, v);
    rdc(evreg_pkg::OFS_INPUT_CFG, v);
    wr_reg(evreg_pkg::OFS_IRQ_STATUS, 32'h7);
    wr_reg(evreg_pkg::OFS_STORE, 32'h2);
    cyc(1);
    chk({31'h0, busy}, 32'h0);
    wr_reg(evreg_pkg::OFS_STORE, 32'h1);
    wait_busy(1'b0);
    chk_in(n, STC - 1, STC + 1);
    rdc(evreg_pkg::OFS_IRQ_STATUS, 32'h4);
    // both buttons held through power-up reload defaults and store them
    do_reset(1'b1);
    cyc(STA + 4);
    chk({30'h0, disp, busy}, 32'h3);
    chk({22'h0, ilock, run, cset}, 32'h301);
    rdc(evreg_pkg::OFS_STORE, 32'h1);
    @(posedge clk_in);
    btn <= 1'b0;
    wait_busy(1'b0);
    end_of_test();
  end
endmodule
